// ---- core/btcs_pkg.sv ----
// constants for the two-beat common-io static memory core
// Behaviour
// - every read and write moves exactly two data beats; burst length fixed
// - address, read and write indication captured on primary input clock rise
// - write beat 0 and its mask on primary rise, beat 1 and its mask on complement rise
// - write beat 0 one cycle after command into buffer, beat 1 next complement
// - byte masks may change per beat; each lane written independently
// - read beat 0 driven at second output complement rise, 1.5 cycles on
// - read beat 1 driven at next true output clock rise after beat 0, 2 cycles on
// - output clocks both held high means input clocks time read data
// - echo clocks emitted with edges matching driven read data
// - primary rise starts each operation; array work afterwards is self-timed
// - active-low byte mask enables its lane in its beat of a write
// - shared data bus released whenever no read is being driven
// - dll disable low bypasses dll, single read latency, up to 167 MHz
package btcs_pkg;
  localparam int BTCS_BURST_LEN     = 2;
  localparam int BTCS_LANE_W        = 9;
  localparam int BTCS_LANES         = 4;
  localparam int BTCS_ADDR_W        = 19;
  localparam int BTCS_CLK_PERIOD_NS = 10;
  localparam int BTCS_DLL_OFF_FMAX_MHZ = 167;
  // output clock rises counted after a read command before beat 0 launches
  localparam logic [1:0] BTCS_RD_LAUNCH_PH = 2'h2;
  typedef enum logic [1:0] {BTCS_WR_IDLE, BTCS_WR_BEAT0, BTCS_WR_BEAT1} btcs_wr_e;
endpackage : btcs_pkg

// ---- core/btcs_sram_core.sv ----
// two-beat common-io static memory core, link pins sampled on ref_clk
`timescale 1ns/100ps
`default_nettype none
module btcs_sram_core
  import btcs_pkg::*;
#(
  parameter int LANES  = BTCS_LANES,
  parameter int LANE_W = BTCS_LANE_W,
  parameter int ADDR_W = BTCS_ADDR_W
) (
  // system
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // input and output clock pairs
  input  wire logic                      k_clk,
  input  wire logic                      k_clk_n,
  input  wire logic                      c_clk,
  input  wire logic                      c_clk_n,
  // command
  input  wire logic                      load_strobe_n,
  input  wire logic                      read_not_write,
  input  wire logic [ADDR_W-1:0]         access_address,
  input  wire logic [LANES-1:0]          byte_write_mask_n,
  input  wire logic                      dll_off_n,
  // shared data bus
  input  wire logic [LANES*LANE_W-1:0]   dq_in,
  output logic      [LANES*LANE_W-1:0]   dq_out,
  output logic                           dq_oe,
  // echo clocks and status
  output logic                           echo_clock_true,
  output logic                           echo_clock_complement,
  output logic                           dll_bypassed
);
  localparam int DW   = LANES * LANE_W;
  // four clock pins, load, direction and dll disable ahead of the wide fields
  localparam int IN_W = 7 + ADDR_W + LANES + DW;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; clocks keep a third stage for edge finding
  logic [IN_W-1:0] s1_q, s2_q;
  logic [3:0]      clk_s3_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q     <= '0;
      s2_q     <= '0;
      clk_s3_q <= '0;
    end else begin
      s1_q     <= {k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, read_not_write,
                   dll_off_n, access_address, byte_write_mask_n, dq_in};
      s2_q     <= s1_q;
      clk_s3_q <= s2_q[IN_W-1 -: 4];
    end
  end

  logic              k_s, kn_s, c_s, cn_s, ld_n_s, rnw_s, dll_s;
  logic [ADDR_W-1:0] addr_s;
  logic [LANES-1:0]  bw_n_s;
  logic [DW-1:0]     d_s;
  assign {k_s, kn_s, c_s, cn_s, ld_n_s, rnw_s, dll_s, addr_s, bw_n_s, d_s} = s2_q;

  logic k_rise, kn_rise, c_tied, out_t_rise, out_c_rise;
  assign k_rise  = k_s & ~clk_s3_q[3];
  assign kn_rise = kn_s & ~clk_s3_q[2];
  assign c_tied  = c_s & cn_s;
  assign out_t_rise = c_tied ? k_rise  : (c_s & ~clk_s3_q[1]);
  assign out_c_rise = c_tied ? kn_rise : (cn_s & ~clk_s3_q[0]);

  logic cmd_go, cmd_rd, cmd_wr;
  assign cmd_go = k_rise & ~ld_n_s;
  assign cmd_rd = cmd_go & rnw_s;
  assign cmd_wr = cmd_go & ~rnw_s;

  //////////////////////////////////////////////////////////////////////////////
  // late-write buffer: holds one burst until the next write command
  btcs_wr_e          wr_st_q;
  logic              buf_v_q;
  logic [ADDR_W-1:0] buf_a_q;
  logic [DW-1:0]     buf_d_q [BTCS_BURST_LEN];
  logic [LANES-1:0]  buf_m_q [BTCS_BURST_LEN];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_st_q    <= BTCS_WR_IDLE;
      buf_v_q    <= 1'b0;
      buf_a_q    <= '0;
      buf_d_q[0] <= '0;
      buf_d_q[1] <= '0;
      buf_m_q[0] <= '1;
      buf_m_q[1] <= '1;
    end else begin
      case (wr_st_q)
        BTCS_WR_IDLE: begin
          if (cmd_wr) begin
            buf_v_q <= 1'b0;
            buf_a_q <= addr_s;
            wr_st_q <= BTCS_WR_BEAT0;
          end
        end
        BTCS_WR_BEAT0: begin
          if (k_rise) begin
            buf_d_q[0] <= d_s;
            buf_m_q[0] <= bw_n_s;
            wr_st_q    <= BTCS_WR_BEAT1;
          end
        end
        BTCS_WR_BEAT1: begin
          if (kn_rise) begin
            buf_d_q[1] <= d_s;
            buf_m_q[1] <= bw_n_s;
            buf_v_q    <= 1'b1;
            wr_st_q    <= BTCS_WR_IDLE;
          end
        end
        default: wr_st_q <= BTCS_WR_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // array: flushed lane by lane when a new write displaces the buffer
  logic [DW-1:0] mem [2**(ADDR_W+1)];

  // lanes whose mask is low take the new byte, the rest keep the old one
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_d, input logic [DW-1:0] new_d,
                                               input logic [LANES-1:0] mask_n);
    logic [DW-1:0] r;
    r = old_d;
    for (int l = 0; l < LANES; l++) begin
      if (!mask_n[l]) r[l*LANE_W +: LANE_W] = new_d[l*LANE_W +: LANE_W];
    end
    return r;
  endfunction : lane_merge

  logic flush;
  assign flush = cmd_wr & buf_v_q & (wr_st_q == BTCS_WR_IDLE);
  always_ff @(posedge ref_clk) begin
    if (flush) begin
      for (int b = 0; b < BTCS_BURST_LEN; b++) begin
        mem[{buf_a_q, 1'(b)}] <= lane_merge(mem[{buf_a_q, 1'(b)}], buf_d_q[b], buf_m_q[b]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read fetch, with buffered data forwarded on an address hit
  logic          rd_hit;
  logic [DW-1:0] rd_b0, rd_b1;
  assign rd_hit = buf_v_q & (buf_a_q == addr_s);
  assign rd_b0  = rd_hit ? lane_merge(mem[{addr_s, 1'b0}], buf_d_q[0], buf_m_q[0]) : mem[{addr_s, 1'b0}];
  assign rd_b1  = rd_hit ? lane_merge(mem[{addr_s, 1'b1}], buf_d_q[1], buf_m_q[1]) : mem[{addr_s, 1'b1}];

  logic          rd_pend_q, beat1_pend_q, beat1_q;
  logic [1:0]    rd_ph_q;
  logic [DW-1:0] rd_b0_q, rd_b1_q, hold_b1_q;

  // a new read may land while the previous beat 1 still drives, so the
  // fetch stage and the drive stage keep separate registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_q <= 1'b0;
      rd_ph_q   <= '0;
      rd_b0_q   <= '0;
      rd_b1_q   <= '0;
    end else if (cmd_rd) begin
      rd_pend_q <= 1'b1;
      rd_ph_q   <= '0;
      rd_b0_q   <= rd_b0;
      rd_b1_q   <= rd_b1;
    end else if (rd_pend_q && (out_t_rise || out_c_rise)) begin
      if (out_c_rise && rd_ph_q == BTCS_RD_LAUNCH_PH) rd_pend_q <= 1'b0;
      else rd_ph_q <= rd_ph_q + 2'h1;
    end
  end

  logic launch;
  assign launch = rd_pend_q & ~cmd_rd & out_c_rise & (rd_ph_q == BTCS_RD_LAUNCH_PH);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dq_out       <= '0;
      dq_oe        <= 1'b0;
      beat1_pend_q <= 1'b0;
      beat1_q      <= 1'b0;
      hold_b1_q    <= '0;
    end else if (launch) begin
      dq_out       <= rd_b0_q;
      hold_b1_q    <= rd_b1_q;
      dq_oe        <= 1'b1;
      beat1_pend_q <= 1'b1;
      beat1_q      <= 1'b0;
    end else if (beat1_pend_q && out_t_rise) begin
      dq_out       <= hold_b1_q;
      beat1_pend_q <= 1'b0;
      beat1_q      <= 1'b1;
    end else if (beat1_q && out_c_rise) begin
      dq_oe   <= 1'b0;
      beat1_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // echo clocks follow the chosen output clock pair and run free
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      echo_clock_true       <= 1'b0;
      echo_clock_complement <= 1'b0;
      dll_bypassed          <= 1'b1;
    end else begin
      echo_clock_true       <= c_tied ? k_s  : c_s;
      echo_clock_complement <= c_tied ? kn_s : cn_s;
      // no dll here: one read latency always, so bypass is only reported
      dll_bypassed          <= ~dll_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // beats driven and captured per burst, so the fixed length is checked by
  // counting and not only through the state flags that produce it
  logic [1:0] rd_beats_q, wr_beats_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_beats_q <= '0;
    end else if (launch) begin
      rd_beats_q <= 2'h1;
    end else if (beat1_pend_q && out_t_rise) begin
      rd_beats_q <= rd_beats_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_beats_q <= '0;
    end else if (cmd_wr && wr_st_q == BTCS_WR_IDLE) begin
      wr_beats_q <= '0;
    end else if ((wr_st_q == BTCS_WR_BEAT0 && k_rise) || (wr_st_q == BTCS_WR_BEAT1 && kn_rise)) begin
      wr_beats_q <= wr_beats_q + 2'h1;
    end
  end

  AST_BEAT0_ON_COMP: assert property ($rose(dq_oe) |-> $past(out_c_rise) && $past(rd_ph_q) == BTCS_RD_LAUNCH_PH)
    else $error("read beat 0 not on second output complement rise");
  AST_BEAT1_ON_TRUE: assert property ($rose(beat1_q) |-> $past(out_t_rise) && dq_out == $past(hold_b1_q))
    else $error("read beat 1 not on output true rise");
  AST_TWO_BEATS: assert property ($fell(dq_oe) |-> $past(beat1_q) && !beat1_pend_q)
    else $error("bus released before second beat");
  AST_BUS_RELEASE: assert property (dq_oe |-> (beat1_pend_q || beat1_q))
    else $error("bus driven with no read beat pending");
  AST_ECHO_MATCH: assert property (out_t_rise && !c_tied |=> echo_clock_true && !$past(clk_s3_q[1]))
    else $error("echo true clock misses output clock rise");
  AST_TIED_USES_K: assert property (c_tied |-> (out_t_rise == k_rise) && (out_c_rise == kn_rise))
    else $error("tied output clocks not replaced by input clocks");
  AST_CMD_ON_K: assert property (wr_st_q == BTCS_WR_IDLE ##1 wr_st_q == BTCS_WR_BEAT0 |-> $past(cmd_wr))
    else $error("write command taken off primary rise");
  AST_BEAT_CAPTURE: assert property (wr_st_q == BTCS_WR_BEAT1 && kn_rise |=> buf_v_q
                                     && buf_d_q[1] == $past(d_s) && buf_m_q[1] == $past(bw_n_s))
    else $error("write beat 1 not captured on complement rise");
  AST_HIT_FWD: assert property (cmd_rd && rd_hit && buf_m_q[0] == '0 |=> rd_b0_q == buf_d_q[0])
    else $error("read hit did not return buffered data");
  AST_DLL: assert property (##2 dll_bypassed == !$past(dll_off_n, 3))
    else $error("dll bypass flag does not follow disable input");

  // read path
  AST_RD_TAKEN: assert property (cmd_rd |=> rd_pend_q && rd_ph_q == 2'h0)
    else $error("read command not taken on primary rise");
  AST_RD_STEADY: assert property (!launch && !(beat1_pend_q && out_t_rise) |=> $stable(dq_out))
    else $error("read data changed off its output clock edge");
  AST_RD_LEN: assert property ($fell(dq_oe) |-> rd_beats_q == 2'(BTCS_BURST_LEN))
    else $error("read burst length is not two beats");
  AST_BEAT1_HOLD: assert property (beat1_q && !out_c_rise && !launch |=> beat1_q && dq_oe)
    else $error("read beat 1 dropped before the next complement rise");
  AST_IDLE_RELEASE: assert property (!rd_pend_q && !beat1_pend_q && !beat1_q |=> !dq_oe)
    else $error("bus driven with no read in progress");

  // write path
  AST_WR_BEAT0: assert property (wr_st_q == BTCS_WR_BEAT0 && k_rise |=> wr_st_q == BTCS_WR_BEAT1
                                 && buf_d_q[0] == $past(d_s) && buf_m_q[0] == $past(bw_n_s))
    else $error("write beat 0 not captured on primary rise");
  AST_WR_LEN: assert property ($rose(buf_v_q) |-> wr_beats_q == 2'(BTCS_BURST_LEN))
    else $error("write burst length is not two beats");
  AST_WR_BUSY: assert property (cmd_wr && wr_st_q != BTCS_WR_IDLE |=> buf_a_q == $past(buf_a_q))
    else $error("write command taken while beats still pending");
  AST_FLUSH: assert property (cmd_wr && wr_st_q == BTCS_WR_IDLE |=> !buf_v_q && buf_a_q == $past(addr_s))
    else $error("new write did not displace the buffered burst");

  // clocks and echoes
  AST_ECHO_COMP: assert property (out_c_rise && !c_tied |=> echo_clock_complement)
    else $error("echo complement clock misses output clock rise");
  AST_ECHO_TIED: assert property (c_tied |=> echo_clock_true == $past(k_s))
    else $error("tied output clocks do not steer echo from input clock");

  // main scenarios
  COV_READ: cover property (cmd_rd ##[1:80] $rose(dq_oe));
  COV_WRITE: cover property (cmd_wr ##[1:80] $rose(buf_v_q));
  COV_HIT: cover property (cmd_rd && rd_hit);
  COV_TIED: cover property (c_tied && launch);
  COV_UNTIED: cover property (!c_tied && launch);
endmodule : btcs_sram_core
`default_nettype wire

// ---- bench/btcs_ctrl_model.sv ----
// controller-side model: link clocks, commands and write beats
`timescale 1ns/100ps
`default_nettype none
module btcs_ctrl_model
  import btcs_pkg::*;
#(
  parameter int AW = 6
) (
  // system
  input  wire logic        ref_clk,
  // link pins towards the core
  output logic             k_clk,
  output logic             k_clk_n,
  output logic             load_strobe_n,
  output logic             read_not_write,
  output logic [AW-1:0]    access_address,
  output logic [3:0]       byte_write_mask_n,
  output logic [35:0]      ctl_dq
);
  initial begin
    k_clk = 1'b0;
    k_clk_n = 1'b1;
    load_strobe_n = 1'b1;
    read_not_write = 1'b1;
    access_address = '0;
    byte_write_mask_n = 4'hf;
    ctl_dq = 36'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one half link period is 8 ref cycles
  task automatic half(input logic k, input logic ld_n, input logic rnw, input logic [AW-1:0] a,
                      input logic [3:0] m, input logic [35:0] d, input logic drv);
    @(posedge ref_clk);
    k_clk <= k;
    k_clk_n <= ~k;
    load_strobe_n <= ld_n;
    read_not_write <= rnw;
    access_address <= a;
    byte_write_mask_n <= m;
    // a released bus shows the inverse of its last value, never a held copy
    ctl_dq <= drv ? d : ~ctl_dq;
    repeat (7) @(posedge ref_clk);
  endtask : half
  task automatic op(input logic rnw, input logic [AW-1:0] a, input logic [3:0] m0, input logic [3:0] m1,
                    input logic [35:0] d0, input logic [35:0] d1);
    half(1'b1, 1'b0, rnw, a, 4'hf, 36'h0, 1'b0);  // command slot
    half(1'b0, 1'b1, rnw, a, 4'hf, 36'h0, 1'b0);
    half(1'b1, 1'b1, rnw, a, m0, d0, ~rnw);  // beat 0 one cycle on
    half(1'b0, 1'b1, rnw, a, m1, d1, ~rnw);  // beat 1 on complement rise
    half(1'b1, 1'b1, rnw, a, 4'hf, 36'h0, 1'b0);  // idle slot
    half(1'b0, 1'b1, rnw, a, 4'hf, 36'h0, 1'b0);
  endtask : op
endmodule : btcs_ctrl_model
`default_nettype wire

// ---- bench/tb_burst_two_common_io_sram.sv ----
// self-checking bench for the two-beat common-io static memory core
`timescale 1ns/100ps
`default_nettype none
module tb_burst_two_common_io_sram;
  import btcs_pkg::*;
  logic              ref_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              k_clk, k_clk_n, load_strobe_n, read_not_write, dll_off_n, tied;
  logic              dq_oe, echo_t, echo_c, dll_bypassed;
  wire logic         c_clk, c_clk_n;
  logic [5:0]        access_address;
  logic [3:0]        byte_write_mask_n;
  logic [35:0]       ctl_dq, dq_out;
  wire logic [35:0]  dq_in;
  logic [35:0]       mem [logic [4:0]];
  logic [31:0]       lfsr_q = 32'hbcc07722;
  int                failures = 0;
  int                n_tests = 0;
  int                cycles = 0;
  always #5 ref_clk = ~ref_clk;
  assign c_clk = tied | k_clk;
  assign c_clk_n = tied | k_clk_n;
  assign dq_in = dq_oe ? dq_out : ctl_dq;
  btcs_ctrl_model #(.AW(6)) m (.ref_clk(ref_clk), .k_clk(k_clk), .k_clk_n(k_clk_n), .load_strobe_n(load_strobe_n),
    .read_not_write(read_not_write), .access_address(access_address), .byte_write_mask_n(byte_write_mask_n),
    .ctl_dq(ctl_dq));
  btcs_sram_core #(.ADDR_W(6)) DUT (.ref_clk(ref_clk), .resetn(resetn), .k_clk(k_clk), .k_clk_n(k_clk_n),
    .c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write),
    .access_address(access_address), .byte_write_mask_n(byte_write_mask_n), .dll_off_n(dll_off_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_clock_true(echo_t),
    .echo_clock_complement(echo_c), .dll_bypassed(dll_bypassed));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] next();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : next
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] mk);
    for (int i = 0; i < 4; i++) begin
      if (!mk[i]) o[i*9+:9] = n[i*9+:9];
    end
    return o;
  endfunction : merge
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // i picks one of 16 addresses, 0 and 63 among them
  task automatic op(input logic rnw, input logic [3:0] i, input logic [3:0] m0, input logic [3:0] m1,
                    input logic [35:0] d0, input logic [35:0] d1);
    logic [35:0] e0;
    logic [35:0] e1;
    e0 = mem.exists({i, 1'b0}) ? mem[{i, 1'b0}] : 36'h0;
    e1 = mem.exists({i, 1'b1}) ? mem[{i, 1'b1}] : 36'h0;
    fork
      m.op(rnw, {i, i[1:0]}, m0, m1, d0, d1);
      begin
        repeat (24) @(posedge ref_clk);
        #1 chk(36'(dq_oe), 36'h0);
        repeat (8) @(posedge ref_clk);
        #1;
        if (rnw) begin
          chk(dq_out, e0);
          chk(36'(dq_oe), 36'h1);
          chk(36'(echo_c), 36'h1);
        end
        repeat (8) @(posedge ref_clk);
        #1;
        if (rnw) begin
          chk(dq_out, e1);
          chk(36'(echo_t), 36'h1);
        end
        repeat (8) @(posedge ref_clk);
        #1 chk(36'(dq_oe), 36'h0);
      end
    join
    if (!rnw) begin
      mem[{i, 1'b0}] = merge(e0, d0, m0);
      mem[{i, 1'b1}] = merge(e1, d1, m1);
    end
  endtask : op
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    tied = 1'b1;
    dll_off_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(36'(dll_bypassed), 36'h1);
    dll_off_n <= 1'b1;
    for (int i = 0; i < 16; i++) op(1'b0, 4'(i), 4'h0, 4'h0, 36'({next(), next()}), 36'({next(), next()}));
    chk(36'(dll_bypassed), 36'h0);
    $display("test fill done");
    op(1'b0, 4'hf, 4'ha, 4'h5, 36'({next(), next()}), 36'({next(), next()}));
    op(1'b1, 4'hf, 4'hf, 4'hf, 36'h0, 36'h0);
    op(1'b0, 4'h0, 4'hf, 4'hf, 36'({next(), next()}), 36'h0);
    op(1'b1, 4'h0, 4'hf, 4'hf, 36'h0, 36'h0);
    $display("test corner done");
    for (int md = 0; md < 2; md++) begin
      tied <= (md == 0);
      for (int n = 0; n < 30; n++) begin
        op(next() > 32'h7fffffff, 4'(next()), 4'(next()), 4'(next()), 36'({next(), next()}),
           36'({next(), next()}));
      end
      $display("test random mode %0d done", md);
    end
    summarize();
  end
endmodule : tb_burst_two_common_io_sram
`default_nettype wire
